/* File: rtl/rrx_exec.sv */
// execution of the return and rotate-left-through-carry instructions
//
// Overview of operation
// - irq return: load pc, pop, enable interrupts
// - literal return writes literal into accumulator
// - literal return then loads pc, pops, two cycles
// - plain return loads pc, pops, two cycles
// - rotate left through carry, updates carry, zero
// - destination bit picks accumulator or file register
`timescale 1ns/1ps

module rrx_exec
  import rrx_pkg::*;
#(
  parameter int DATA_W = RRX_DATA_W,
  parameter int PC_W = RRX_PC_W
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  // instruction request
  input wire logic exec_valid,
  input wire rrx_op_type exec_op,
  input wire logic [DATA_W-1:0] exec_literal,
  input wire logic exec_dest,
  input wire logic [DATA_W-1:0] exec_file_addr,
  // operands from the core
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  input wire logic [PC_W-1:0] stack_top,
  // status
  output logic busy_q,
  // program counter and stack
  output logic pc_load_q,
  output logic [PC_W-1:0] pc_value_q,
  output logic stack_pop_q,
  // interrupt enable
  output logic gie_set_q,
  output logic gie_value_q,
  // accumulator write
  output logic acc_we_q,
  output logic [DATA_W-1:0] acc_wdata_q,
  // file register write
  output logic file_we_q,
  output logic [DATA_W-1:0] file_addr_q,
  output logic [DATA_W-1:0] file_wdata_q,
  // flag write
  output logic flag_we_q,
  output logic carry_q,
  output logic zero_q
);

  rrx_state_type state_q;
  rrx_op_type op_q;
  logic accept;
  logic [DATA_W-1:0] rot_result;
  logic rot_carry;
  logic is_rotate;

  // a request is taken only in the first state
  assign accept = clk_en && exec_valid && (state_q == RRX_ST_FIRST);
  assign is_rotate = (exec_op == RRX_OP_ROTATE_LEFT_CARRY);

  // rotate left through carry
  assign rot_result = {file_rdata[DATA_W-2:RRX_LSB_POS], carry_in};
  assign rot_carry = file_rdata[RRX_MSB_POS];

  // two-state sequencer, returns stay for a second cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= RRX_ST_FIRST;
      op_q <= RRX_OP_RETURN_SUB;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        RRX_ST_FIRST: begin
          if (accept && !is_rotate) begin
            state_q <= RRX_ST_SECOND;
            op_q <= exec_op;
            busy_q <= 1'b1;
          end
        end
        RRX_ST_SECOND: begin
          state_q <= RRX_ST_FIRST;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= RRX_ST_FIRST;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // pc reload and stack pop in the second cycle of every return
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pc_load_q <= 1'b0;
      stack_pop_q <= 1'b0;
      pc_value_q <= '0;
    end else if (clk_en) begin
      pc_load_q <= (state_q == RRX_ST_SECOND);
      stack_pop_q <= (state_q == RRX_ST_SECOND);
      if (state_q == RRX_ST_SECOND) begin
        pc_value_q <= stack_top;
      end
    end
  end

  // global interrupt enable set on interrupt return only
  always_ff @(posedge clock) begin
    if (!resetn) begin
      gie_set_q <= 1'b0;
      gie_value_q <= RRX_FLAG_RST;
    end else if (clk_en) begin
      gie_set_q <= (state_q == RRX_ST_SECOND) &&
                   (op_q == RRX_OP_RETURN_FROM_IRQ);
      gie_value_q <= RRX_GIE_SET_VALUE;
    end
  end

  // accumulator write: literal return or rotate to accumulator
  always_ff @(posedge clock) begin
    if (!resetn) begin
      acc_we_q <= 1'b0;
      acc_wdata_q <= RRX_DATA_RST;
    end else if (clk_en) begin
      acc_we_q <= 1'b0;
      if (accept && exec_op == RRX_OP_RETURN_WITH_LITERAL) begin
        acc_we_q <= 1'b1;
        acc_wdata_q <= exec_literal;
      end else if (accept && is_rotate && exec_dest == RRX_DEST_ACC) begin
        acc_we_q <= 1'b1;
        acc_wdata_q <= rot_result;
      end
    end
  end

  // file register write-back of the rotate
  always_ff @(posedge clock) begin
    if (!resetn) begin
      file_we_q <= 1'b0;
      file_addr_q <= RRX_DATA_RST;
      file_wdata_q <= RRX_DATA_RST;
    end else if (clk_en) begin
      file_we_q <= accept && is_rotate && (exec_dest == RRX_DEST_FILE);
      if (accept && is_rotate) begin
        file_addr_q <= exec_file_addr;
        file_wdata_q <= rot_result;
      end
    end
  end

  // carry and zero update, rotate only; returns leave flags alone
  always_ff @(posedge clock) begin
    if (!resetn) begin
      flag_we_q <= 1'b0;
      carry_q <= RRX_FLAG_RST;
      zero_q <= RRX_FLAG_RST;
    end else if (clk_en) begin
      flag_we_q <= accept && is_rotate;
      if (accept && is_rotate) begin
        carry_q <= rot_carry;
        zero_q <= (rot_result == '0);
      end
    end
  end

  // checks on the executed sequences
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn || !clk_en);

  sequence s_take(rrx_op_type op);
    accept && exec_op == op;
  endsequence

  sequence s_ret_done;
    pc_load_q && stack_pop_q && !busy_q;
  endsequence

  AST_IRQ_RET_GIE: assert property (
    s_take(RRX_OP_RETURN_FROM_IRQ) |=> busy_q && !pc_load_q && !flag_we_q
      ##1 (s_ret_done and (gie_set_q && gie_value_q && !flag_we_q)))
    else $error("irq return did not reload pc and set enable");

  AST_LIT_ACC: assert property (
    s_take(RRX_OP_RETURN_WITH_LITERAL) |=> acc_we_q && !flag_we_q &&
      acc_wdata_q == $past(exec_literal))
    else $error("literal return did not load accumulator");

  AST_LIT_POP: assert property (
    s_take(RRX_OP_RETURN_WITH_LITERAL) |=> busy_q ##1 (s_ret_done and
      (!gie_set_q && !acc_we_q)))
    else $error("literal return did not pop in two cycles");

  AST_PLAIN_RET: assert property (
    s_take(RRX_OP_RETURN_SUB) |=> (busy_q && !pc_load_q && !flag_we_q)
      ##1 (s_ret_done and (!gie_set_q && !flag_we_q)))
    else $error("plain return wrong timing or side effect");

  // completing return leaves flags and registers alone
  AST_RET_NO_FLAGS: assert property (
    pc_load_q |-> !flag_we_q && !file_we_q && !acc_we_q)
    else $error("return completion touched flags or registers");

  // cycles count only enabled edges, so a low enable holds everything
  AST_FREEZE: assert property (
    @(posedge clock) disable iff (!resetn)
    !clk_en |=> $stable({busy_q, pc_load_q, stack_pop_q, gie_set_q,
      acc_we_q, file_we_q, flag_we_q, pc_value_q, acc_wdata_q}))
    else $error("outputs moved while clock enable was low");

  AST_PC_FROM_STACK: assert property (
    busy_q |=> pc_value_q == $past(stack_top))
    else $error("pc not taken from stack top");

  AST_ROT_RESULT: assert property (
    s_take(RRX_OP_ROTATE_LEFT_CARRY) |=> flag_we_q && !busy_q &&
      carry_q == $past(file_rdata[7]) &&
      file_wdata_q == {$past(file_rdata[6:0]), $past(carry_in)} &&
      zero_q == (file_wdata_q == 8'h00))
    else $error("rotate result or flags wrong");

  AST_ROT_DEST: assert property (
    s_take(RRX_OP_ROTATE_LEFT_CARRY) |=> acc_we_q == !$past(exec_dest) &&
      file_we_q == $past(exec_dest) &&
      (!acc_we_q || acc_wdata_q == file_wdata_q))
    else $error("rotate written to wrong destination");

endmodule

/* File: shared/rrx_pkg.sv */
// constants and types for the return and rotate execution block
package rrx_pkg;

  // operand and result width of the data path
  localparam int RRX_DATA_W = 8;
  // default program counter width
  localparam int RRX_PC_W = 16;

  // destination select encoding
  localparam logic RRX_DEST_ACC = 1'b0;
  localparam logic RRX_DEST_FILE = 1'b1;

  // value written to the global interrupt enable on interrupt return
  localparam logic RRX_GIE_SET_VALUE = 1'b1;

  // bit positions of the rotate
  localparam int RRX_MSB_POS = 7;
  localparam int RRX_LSB_POS = 0;

  // reset values of the data outputs
  localparam logic [7:0] RRX_DATA_RST = 8'h00;
  localparam logic RRX_FLAG_RST = 1'b0;

  // instruction selector
  typedef enum logic [1:0] {
    RRX_OP_RETURN_SUB = 2'h0,
    RRX_OP_RETURN_FROM_IRQ = 2'h1,
    RRX_OP_RETURN_WITH_LITERAL = 2'h2,
    RRX_OP_ROTATE_LEFT_CARRY = 2'h3
  } rrx_op_type;

  // execution state, a return occupies both
  typedef enum logic [0:0] {
    RRX_ST_FIRST = 1'h0,
    RRX_ST_SECOND = 1'h1
  } rrx_state_type;

endpackage

/* File: verification/rrx_exec_bench.sv */
// self-checking bench for the return and rotate execution block
`timescale 1ns/1ps

module rrx_exec_bench import rrx_pkg::*;;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic exec_valid = 1'b0;
  rrx_op_type exec_op = RRX_OP_RETURN_SUB;
  logic [7:0] exec_literal = 8'h00;
  logic exec_dest = 1'b0;
  logic [7:0] exec_file_addr = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic carry_in = 1'b0;
  logic [15:0] stack_top = 16'h0000;
  logic busy_q, pc_load_q, stack_pop_q, gie_set_q, gie_value_q;
  logic acc_we_q, file_we_q, flag_we_q, carry_q, zero_q;
  logic [15:0] pc_value_q;
  logic [7:0] acc_wdata_q, file_addr_q, file_wdata_q;
  int err_count = 0;
  int checked = 0;

  rrx_exec dut_u (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_literal(exec_literal),
    .exec_dest(exec_dest), .exec_file_addr(exec_file_addr),
    .file_rdata(file_rdata), .carry_in(carry_in), .stack_top(stack_top),
    .busy_q(busy_q), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
    .stack_pop_q(stack_pop_q), .gie_set_q(gie_set_q),
    .gie_value_q(gie_value_q), .acc_we_q(acc_we_q),
    .acc_wdata_q(acc_wdata_q), .file_we_q(file_we_q),
    .file_addr_q(file_addr_q), .file_wdata_q(file_wdata_q),
    .flag_we_q(flag_we_q), .carry_q(carry_q), .zero_q(zero_q));

  // 250 MHz clock
  always #2 clock = ~clock;

  // compare one value, count and report
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask

  // rotate with given destination, operand and carry
  task automatic rot(input logic d, input logic [7:0] f, input logic c);
    logic [7:0] r;
    r = {f[6:0], c};
    exec_valid = 1'b1;
    exec_op = RRX_OP_ROTATE_LEFT_CARRY;
    exec_dest = d;
    file_rdata = f;
    carry_in = c;
    exec_file_addr = ~f;
    @(negedge clock);
    exec_valid = 1'b0;
    chk("acc_we", acc_we_q, !d);
    chk("file_we", file_we_q, d);
    chk("flag_we", flag_we_q, 1'b1);
    chk("wdata", d ? file_wdata_q : acc_wdata_q, r);
    if (d) chk("faddr", file_addr_q, {8'h00, ~f});
    chk("carry", carry_q, f[7]);
    chk("zero", zero_q, r == 8'h00);
    @(negedge clock);
    chk("flag_we end", flag_we_q, 1'b0);
  endtask

  // return of given kind; a rotate offered while busy must be dropped
  task automatic ret(input rrx_op_type op, input logic [7:0] k,
    input logic [15:0] top);
    exec_valid = 1'b1;
    exec_op = op;
    exec_literal = k;
    @(negedge clock);
    exec_op = RRX_OP_ROTATE_LEFT_CARRY;
    stack_top = top;
    chk("busy", busy_q, 1'b1);
    chk("acc_we", acc_we_q, op == RRX_OP_RETURN_WITH_LITERAL);
    if (op == RRX_OP_RETURN_WITH_LITERAL) chk("acc", acc_wdata_q, k);
    chk("pc_load early", pc_load_q, 1'b0);
    chk("flag_we ret", flag_we_q, 1'b0);
    @(negedge clock);
    exec_valid = 1'b0;
    stack_top = ~top;
    chk("pc_load", pc_load_q, 1'b1);
    chk("pop", stack_pop_q, 1'b1);
    chk("pc_value", pc_value_q, top);
    chk("gie_set", gie_set_q, op == RRX_OP_RETURN_FROM_IRQ);
    chk("gie_value", gie_value_q, RRX_GIE_SET_VALUE);
    chk("busy end", busy_q, 1'b0);
    chk("acc_we late", acc_we_q, 1'b0);
    chk("refused", file_we_q | flag_we_q, 1'b0);
    @(negedge clock);
    chk("pc_load end", pc_load_q, 1'b0);
    chk("pop end", stack_pop_q, 1'b0);
  endtask

  // enable low freezes a return mid-way and holds its pulses
  task automatic frz(input logic [15:0] top);
    exec_valid = 1'b1;
    exec_op = RRX_OP_RETURN_FROM_IRQ;
    @(negedge clock);
    exec_valid = 1'b0;
    clk_en = 1'b0;
    stack_top = top;
    repeat (2) @(negedge clock);
    chk("frozen busy", busy_q, 1'b1);
    chk("frozen pc_load", pc_load_q, 1'b0);
    clk_en = 1'b1;
    @(negedge clock);
    clk_en = 1'b0;
    exec_valid = 1'b1;
    exec_op = RRX_OP_ROTATE_LEFT_CARRY;
    chk("pc_value frz", pc_value_q, top);
    chk("gie_set frz", gie_set_q, 1'b1);
    @(negedge clock);
    exec_valid = 1'b0;
    clk_en = 1'b1;
    chk("held pc_load", pc_load_q, 1'b1);
    chk("held gie_set", gie_set_q, 1'b1);
    chk("frozen take", flag_we_q, 1'b0);
    @(negedge clock);
    chk("pc_load end frz", pc_load_q, 1'b0);
    chk("no late take", flag_we_q, 1'b0);
  endtask

  // reset in the busy cycle cancels the pending reload
  task automatic rst_mid();
    exec_valid = 1'b1;
    exec_op = RRX_OP_RETURN_SUB;
    @(negedge clock);
    exec_valid = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b0;
    @(negedge clock);
    resetn = 1'b1;
    clk_en = 1'b1;
    chk("reset busy", {busy_q, pc_load_q, gie_value_q}, 16'h0000);
    @(negedge clock);
    chk("no reload", pc_load_q, 1'b0);
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (5) @(negedge clock);
    chk("reset outs", {busy_q, pc_load_q, acc_we_q, flag_we_q}, 16'h0000);
    resetn = 1'b1;
    rot(1'b0, 8'hE6, 1'b0);
    rot(1'b1, 8'hE6, 1'b0);
    rot(1'b0, 8'h80, 1'b0);
    rot(1'b1, 8'h7F, 1'b1);
    rot(1'b0, 8'h00, 1'b1);
    ret(RRX_OP_RETURN_SUB, 8'h00, 16'h1234);
    ret(RRX_OP_RETURN_FROM_IRQ, 8'h00, 16'hBEEF);
    ret(RRX_OP_RETURN_WITH_LITERAL, 8'hFF, 16'h0001);
    ret(RRX_OP_RETURN_WITH_LITERAL, 8'h5A, 16'hFFFE);
    frz(16'hA5C3);
    rst_mid();
    summarize();
  end
endmodule
